// ---- tb/sktc_rf_model.sv ----
`timescale 1ns/100ps
module sktc_rf_model (
  input  wire logic [sktc_pkg::FW-1:0] synthFreqKhz,
  input  wire logic [sktc_pkg::FW-1:0] stationKhz,
  output logic                         channelValid
);
  import sktc_pkg::*;
  // a station qualifies only while tuned exactly onto it
  assign channelValid = (synthFreqKhz == stationKhz);
endmodule

// ---- tb/sktc_seek_tune_control_sva.sv ----
`timescale 1ns/100ps
module sktc_seek_tune_control_sva (
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire sktc_pkg::sktc_bus_s     bus,
  input wire logic                    channelValid,
  input wire logic [sktc_pkg::DW-1:0] rdData,
  input wire logic [sktc_pkg::FW-1:0] synthFreqKhz,
  input wire logic                    verboseMode,
  input wire logic                    powerEnable,
  input wire logic                    powerDisable,
  input wire logic                    opComplete,
  input wire logic                    searchFail
);
  import sktc_pkg::*;
  logic tuneReq_q;
  logic seekReq_q;
  wire  chWr   = bus.wr && bus.addr == REG_CHANNEL;
  wire  pcWr   = bus.wr && bus.addr == REG_POWER_CFG;
  wire  anyWr  = chWr || pcWr;
  wire  isFree = !tuneReq_q && !seekReq_q && !opComplete;
  wire  tuneGo = chWr && bus.wdata[TUNEREQ_BIT] && isFree;
  wire  seekGo = pcWr && bus.wdata[SEEKREQ_BIT] && isFree;
  wire  stRd   = bus.rd && bus.addr == REG_STATUS;
  wire  bsWr   = bus.wr && bus.addr == REG_BAND_SPACE;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tuneReq_q <= 1'b0;
      seekReq_q <= 1'b0;
    end else begin
      if (chWr) tuneReq_q <= bus.wdata[TUNEREQ_BIT];
      if (pcWr) seekReq_q <= bus.wdata[SEEKREQ_BIT];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  fail_needs_done_a: assert property (searchFail |-> opComplete)
    else $error("fail flag alone");
  flags_drop_together_a: assert property ($fell(searchFail) |->
    $fell(opComplete)) else $error("flags dropped apart");
  done_clear_cause_a: assert property ($fell(opComplete) |->
    $past(anyWr)) else $error("complete dropped without write");
  tune_not_early_a: assert property (tuneGo |=>
    !opComplete[*8]) else $error("tune done too early");
  seek_moves_a: assert property (seekGo |->
    ##[1:4] ($changed(synthFreqKhz) || opComplete || !seekReq_q))
    else $error("seek did not step");
  done_holds_a: assert property (opComplete && !$past(bsWr) |=>
    $stable(synthFreqKhz)) else $error("tuning moved while done");
  verbose_write_a: assert property (pcWr |=>
    verboseMode == $past(bus.wdata[VERBOSE_BIT])) else $error("verbose");
  status_bits_a: assert property ($past(stRd) |->
    rdData[DONE_BIT] == $past(opComplete) &&
    rdData[FAIL_BIT] == $past(searchFail)) else $error("status read");
  rd_idle_zero_a: assert property (!$past(bus.rd) |-> rdData == '0)
    else $error("read data outside read cycle");
  cover property (tuneGo);
  cover property (seekGo);
  cover property ($rose(searchFail));
endmodule
bind sktc_seek_tune_control sktc_seek_tune_control_sva
  u_sktc_seek_tune_control_sva (
  .clk(clk), .resetn(resetn), .bus(bus), .channelValid(channelValid),
  .rdData(rdData), .synthFreqKhz(synthFreqKhz), .verboseMode(verboseMode),
  .powerEnable(powerEnable), .powerDisable(powerDisable),
  .opComplete(opComplete), .searchFail(searchFail)
);

// ---- tb/tb_seek_tune_control.sv ----
`timescale 1ns/100ps
module tb_seek_tune_control;
  import sktc_pkg::*;
  logic          clk, resetn, channelValid;
  logic          verboseMode, powerEnable, powerDisable;
  logic          opComplete, searchFail;
  sktc_bus_s     bus;
  logic [DW-1:0] rdData, d, flg;
  logic [FW-1:0] synthFreqKhz, stationKhz;
  logic [7:0]    rnd;
  int            fails, nChecks, n, cur, b;
  assign flg = {14'h0, opComplete, searchFail};
  sktc_seek_tune_control u_sktc_seek_tune_control (
    .clk(clk), .resetn(resetn), .bus(bus), .channelValid(channelValid),
    .rdData(rdData), .synthFreqKhz(synthFreqKhz), .verboseMode(verboseMode),
    .powerEnable(powerEnable), .powerDisable(powerDisable),
    .opComplete(opComplete), .searchFail(searchFail)
  );
  sktc_rf_model u_sktc_rf_model (
    .synthFreqKhz(synthFreqKhz), .stationKhz(stationKhz),
    .channelValid(channelValid)
  );
  function automatic logic [FW-1:0] fexp(int bd, int sp, int i);
    return 20'((bd == 0 ? 87500 : 76000) +
      (sp == 0 ? 200 : sp == 1 ? 100 : 50) * i);
  endfunction
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic wr(logic [AW-1:0] a, logic [DW-1:0] v);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [AW-1:0] a);
    bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdData;
  endtask
  task automatic cmp16(logic [DW-1:0] g, logic [DW-1:0] e);
    nChecks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t word %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmpF(logic [FW-1:0] g, logic [FW-1:0] e);
    nChecks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t freq %0d exp %0d", $time, g, e);
    end
  endtask
  task automatic waitDone();
    n = 0;
    while (opComplete !== 1'b1 && n < 8000) begin
      @(posedge clk);
      #1 n++;
    end
    if (opComplete !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t no completion", $time);
    end
  endtask
  task automatic endSim();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #80000;
    fails++;
    endSim();
  end
  initial begin
    bus = '0;
    resetn = 1'b0;
    stationKhz = '0;
    rnd = 8'h12;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    cmpF(synthFreqKhz, 20'd87500);
    rd(REG_CHANNEL);
    cmp16(d, 16'h0);
    rd(4'h7);
    cmp16(d, 16'h0);
    wr(REG_POWER_CFG, 16'h0841);
    cmp16({13'h0, verboseMode, powerDisable, powerEnable}, 16'h7);
    rd(REG_POWER_CFG);
    cmp16(d, 16'h0841);
    $display("test registers done");
    for (b = 0; b < 3; b++) begin
      cur = rnd[7:2];
      wr(REG_BAND_SPACE, {8'h0, 2'(b), rnd[1:0], 4'h0});
      wr(REG_CHANNEL, 16'(16'h8000 + cur));
      waitDone();
      cmp16(16'(n), 16'(SETTLE_CYC));
      cmpF(synthFreqKhz, fexp(b, rnd[1:0], cur));
      rd(REG_READBACK);
      cmp16(d, 16'(cur));
      rd(REG_STATUS);
      cmp16(d, 16'h4000);
      wr(REG_POWER_CFG, 16'h0100);
      wr(REG_CHANNEL, 16'(cur));
      repeat (3) @(posedge clk);
      #1 cmpF(synthFreqKhz, fexp(b, rnd[1:0], cur));
      cmp16(flg, 16'h2);
      wr(REG_POWER_CFG, 16'h0);
      @(posedge clk);
      #1 cmp16(flg, 16'h0);
      rnd = lfsr(rnd);
    end
    $display("test tune done");
    wr(REG_BAND_SPACE, 16'h0);
    stationKhz = fexp(0, 0, cur + 3);
    wr(REG_POWER_CFG, 16'h0300);
    waitDone();
    cmp16(flg, 16'h2);
    rd(REG_READBACK);
    cmp16(d, 16'(cur + 3));
    rd(REG_CHANNEL);
    cmp16(d, 16'(cur));
    wr(REG_POWER_CFG, 16'h0);
    $display("test seek found done");
    stationKhz = '0;
    wr(REG_CHANNEL, 16'h8001);
    waitDone();
    wr(REG_CHANNEL, 16'h0001);
    repeat (2) @(posedge clk);
    #1 wr(REG_POWER_CFG, 16'h0500);
    waitDone();
    cmp16(flg, 16'h3);
    cmpF(synthFreqKhz, 20'd87500);
    wr(REG_POWER_CFG, 16'h0);
    @(posedge clk);
    #1 cmp16(flg, 16'h0);
    $display("test seek edge done");
    stationKhz = fexp(0, 0, 4);
    wr(REG_POWER_CFG, 16'h0300);
    repeat (250) @(posedge clk);
    #1 wr(REG_POWER_CFG, 16'h0200);
    repeat (600) @(posedge clk);
    #1 cmp16(flg, 16'h0);
    $display("test seek abort done");
    stationKhz = '0;
    wr(REG_BAND_SPACE, 16'h0080);
    wr(REG_CHANNEL, 16'h8005);
    waitDone();
    wr(REG_CHANNEL, 16'h0005);
    @(posedge clk);
    #1 wr(REG_POWER_CFG, 16'h0300);
    waitDone();
    cmp16(flg, 16'h3);
    rd(REG_READBACK);
    cmp16(d, 16'h5);
    cmpF(synthFreqKhz, fexp(2, 0, 5));
    wr(REG_POWER_CFG, 16'h0);
    @(posedge clk);
    #1 cmp16(flg, 16'h0);
    $display("test seek wrap done");
    endSim();
  end
endmodule

// ---- verilog/sktc_pkg.sv ----
package sktc_pkg;

  localparam int unsigned AW = 4;
  localparam int unsigned DW = 16;
  localparam int unsigned IW = 10;
  localparam int unsigned FW = 20;

  localparam logic [AW-1:0] REG_POWER_CFG  = 4'h2;
  localparam logic [AW-1:0] REG_CHANNEL    = 4'h3;
  localparam logic [AW-1:0] REG_BAND_SPACE = 4'h5;
  localparam logic [AW-1:0] REG_STATUS     = 4'ha;
  localparam logic [AW-1:0] REG_READBACK   = 4'hb;

  // power configuration fields
  localparam int unsigned VERBOSE_BIT   = 11;
  localparam int unsigned STOPMODE_BIT  = 10;
  localparam int unsigned DIRUP_BIT     = 9;
  localparam int unsigned SEEKREQ_BIT   = 8;
  localparam int unsigned PWRDIS_BIT    = 6;
  localparam int unsigned PWREN_BIT     = 0;
  // channel and band fields
  localparam int unsigned TUNEREQ_BIT   = 15;
  localparam int unsigned BAND_LSB      = 6;
  localparam int unsigned SPACE_LSB     = 4;
  // status fields
  localparam int unsigned DONE_BIT      = 14;
  localparam int unsigned FAIL_BIT      = 13;

  localparam logic [IW-1:0] INDEX_RESET = 10'h000;

  // settle time per tuned channel
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned SETTLE_NS     = 400;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CW            = 10;

  localparam logic [FW-1:0] BASE_LOW_KHZ  = 20'h155cc; // 87500
  localparam logic [FW-1:0] BASE_WIDE_KHZ = 20'h128e0; // 76000

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } sktc_bus_s;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h1,
    ST_TUNE_WAIT = 4'h2,
    ST_SEEK_STEP = 4'h4,
    ST_SEEK_WAIT = 4'h8
  } sktc_state_e;

  // channel spacing in kHz: 00 200, 01 100, 1x 50
  function automatic logic [7:0] spacingKhz(input logic [1:0] sp);
    case (sp)
      2'h0:    spacingKhz = 8'hc8;
      2'h1:    spacingKhz = 8'h64;
      default: spacingKhz = 8'h32;
    endcase
  endfunction

  // highest index in band, spacing 00-10: 87.5-108, 76-108, 76-90 MHz
  function automatic logic [IW-1:0] topIndex(input logic [1:0] band,
                                              input logic [1:0] sp);
    logic [3:0] key;
    key = {band, sp};
    case (key)
      4'h0:    topIndex = 10'h066;
      4'h1:    topIndex = 10'h0cd;
      4'h2:    topIndex = 10'h19a;
      4'h4:    topIndex = 10'h0a0;
      4'h5:    topIndex = 10'h140;
      4'h6:    topIndex = 10'h280;
      4'h8:    topIndex = 10'h046;
      4'h9:    topIndex = 10'h08c;
      4'ha:    topIndex = 10'h118;
      4'hc:    topIndex = 10'h0a0;
      4'hd:    topIndex = 10'h140;
      4'he:    topIndex = 10'h280;
      default: topIndex = 10'h066;
    endcase
  endfunction

  function automatic logic regHit(input logic [AW-1:0] a,
                                  input logic [AW-1:0] r);
    regHit = (a == r);
  endfunction

endpackage

// ---- verilog/sktc_seek_tune_control.sv ----
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
module sktc_seek_tune_control (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire sktc_pkg::sktc_bus_s bus,
  input  wire logic                channelValid,
  output logic [sktc_pkg::DW-1:0]  rdData,
  output logic [sktc_pkg::FW-1:0]  synthFreqKhz,
  output logic                     verboseMode,
  output logic                     powerEnable,
  output logic                     powerDisable,
  output logic                     opComplete,
  output logic                     searchFail
);
  import sktc_pkg::*;

  sktc_state_e    state_q, state_d;
  logic [CW-1:0]  cnt_q, cnt_d;
  logic [IW-1:0]  readback_q, readback_d;
  logic [IW-1:0]  startIdx_q, startIdx_d;
  logic           done_q, done_d;
  logic           fail_q, fail_d;
  logic           verbose_q, stopMode_q, dirUp_q, seekReq_q;
  logic           pwrDis_q, pwrEn_q, tuneReq_q;
  logic [IW-1:0]  target_q;
  logic [1:0]     band_q, space_q;
  logic [DW-1:0]  rdData_q;
  logic [FW-1:0]  freq_q, freq_d;

  wire wrPwr  = bus.wr && regHit(bus.addr, REG_POWER_CFG);
  wire wrChan = bus.wr && regHit(bus.addr, REG_CHANNEL);
  wire wrBand = bus.wr && regHit(bus.addr, REG_BAND_SPACE);

  wire seekNext = wrPwr ? bus.wdata[SEEKREQ_BIT] : seekReq_q;
  wire tuneNext = wrChan ? bus.wdata[TUNEREQ_BIT] : tuneReq_q;
  wire seekRise = wrPwr && bus.wdata[SEEKREQ_BIT] && !seekReq_q;
  wire tuneRise = wrChan && bus.wdata[TUNEREQ_BIT] && !tuneReq_q;
  wire startOk  = (state_q == ST_IDLE) && !done_q;

  wire [IW-1:0] topIdx  = topIndex(band_q, space_q);
  wire          atEdge  = dirUp_q ? (readback_q >= topIdx)
                                  : (readback_q == INDEX_RESET);
  wire [IW-1:0] wrapIdx = dirUp_q ? INDEX_RESET : topIdx;
  wire [IW-1:0] stepIdx = dirUp_q ? readback_q + 10'h001
                                  : readback_q - 10'h001;
  wire [IW-1:0] nextIdx = atEdge ? wrapIdx : stepIdx;
  wire [CW-1:0] settleCnt = CW'(SETTLE_CYC - 1);

  wire [DW-1:0] pwrView = {4'h0, verbose_q, stopMode_q, dirUp_q,
                           seekReq_q, 1'b0, pwrDis_q, 5'h00, pwrEn_q};
  wire [DW-1:0] chanView = {tuneReq_q, 5'h00, target_q};
  wire [DW-1:0] bandView = {8'h00, band_q, space_q, 4'h0};
  wire [DW-1:0] statView = {1'b0, done_q, fail_q, 13'h0000};
  wire [DW-1:0] rbView   = {6'h00, readback_q};

  wire [DW-1:0] rdMux =
      regHit(bus.addr, REG_POWER_CFG)  ? pwrView  :
      regHit(bus.addr, REG_CHANNEL)    ? chanView :
      regHit(bus.addr, REG_BAND_SPACE) ? bandView :
      regHit(bus.addr, REG_STATUS)     ? statView :
      regHit(bus.addr, REG_READBACK)   ? rbView   : 16'h0000;

  wire [FW-1:0] baseKhz = (band_q == 2'h0) ? BASE_LOW_KHZ : BASE_WIDE_KHZ;
  wire [17:0]   offKhz  = 18'(spacingKhz(space_q) * readback_d);
  assign freq_d = FW'(baseKhz + FW'(offKhz));

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    readback_d = readback_q;
    startIdx_d = startIdx_q;
    done_d     = done_q;
    fail_d     = fail_q;
    if (done_q && !seekNext && !tuneNext) begin
      done_d = 1'b0;
      fail_d = 1'b0;
    end
    case (state_q)
      ST_IDLE: begin
        if (tuneRise && startOk) begin
          readback_d = bus.wdata[IW-1:0];
          cnt_d      = settleCnt;
          state_d    = ST_TUNE_WAIT;
        end else if (seekRise && startOk) begin
          startIdx_d = readback_q;
          state_d    = ST_SEEK_STEP;
        end
      end
      ST_TUNE_WAIT: begin
        if (!tuneNext) begin
          state_d = ST_IDLE;
        end else if (cnt_q == '0) begin
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      ST_SEEK_STEP: begin
        if (!seekNext) begin
          state_d = ST_IDLE;
        end else if (atEdge && stopMode_q) begin
          done_d  = 1'b1;
          fail_d  = 1'b1;
          state_d = ST_IDLE;
        end else begin
          readback_d = nextIdx;
          if (nextIdx == startIdx_q) begin
            done_d  = 1'b1;
            fail_d  = 1'b1;
            state_d = ST_IDLE;
          end else begin
            cnt_d   = settleCnt;
            state_d = ST_SEEK_WAIT;
          end
        end
      end
      ST_SEEK_WAIT: begin
        if (!seekNext) begin
          state_d = ST_IDLE;
        end else if (cnt_q != '0) begin
          cnt_d = cnt_q - CW'(1);
        end else if (channelValid) begin
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end else begin
          state_d = ST_SEEK_STEP;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= ST_IDLE;
      cnt_q      <= '0;
      readback_q <= INDEX_RESET;
      startIdx_q <= INDEX_RESET;
      done_q     <= 1'b0;
      fail_q     <= 1'b0;
      freq_q     <= BASE_LOW_KHZ;
      rdData_q   <= '0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      readback_q <= readback_d;
      startIdx_q <= startIdx_d;
      done_q     <= done_d;
      fail_q     <= fail_d;
      freq_q     <= freq_d;
      rdData_q   <= bus.rd ? rdMux : 16'h0000;
    end
  end

  // host registers; target index only host-written
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      verbose_q  <= 1'b0;
      stopMode_q <= 1'b0;
      dirUp_q    <= 1'b0;
      seekReq_q  <= 1'b0;
      pwrDis_q   <= 1'b0;
      pwrEn_q    <= 1'b0;
      tuneReq_q  <= 1'b0;
      target_q   <= INDEX_RESET;
      band_q     <= 2'h0;
      space_q    <= 2'h0;
    end else begin
      if (wrPwr) begin
        verbose_q  <= bus.wdata[VERBOSE_BIT];
        stopMode_q <= bus.wdata[STOPMODE_BIT];
        dirUp_q    <= bus.wdata[DIRUP_BIT];
        seekReq_q  <= bus.wdata[SEEKREQ_BIT];
        pwrDis_q   <= bus.wdata[PWRDIS_BIT];
        pwrEn_q    <= bus.wdata[PWREN_BIT];
      end
      if (wrChan) begin
        tuneReq_q <= bus.wdata[TUNEREQ_BIT];
        target_q  <= bus.wdata[IW-1:0];
      end
      if (wrBand) begin
        band_q  <= bus.wdata[BAND_LSB +: 2];
        space_q <= bus.wdata[SPACE_LSB +: 2];
      end
    end
  end

  assign rdData       = rdData_q;
  assign synthFreqKhz = freq_q;
  assign verboseMode  = verbose_q;
  assign powerEnable  = pwrEn_q;
  assign powerDisable = pwrDis_q;
  assign opComplete   = done_q;
  assign searchFail   = fail_q;

endmodule
